//--- common/emb_pkg.sv
package emb_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int TCP_NS        = 48;
	localparam int DELTA_NS      = 20;
	// one oscillator period in ref_clk cycles (rounded up, least time)
	localparam int TCP_CYC       = (TCP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] TCP_LAST = 4'(TCP_CYC - 1);

	// ------------------------------------------------------------
	// cycle phase counts, in oscillator periods
	// ------------------------------------------------------------
	localparam logic [4:0] PH_ADDR_SETUP = 5'h01;
	localparam logic [4:0] PH_ALE        = 5'h02;
	localparam logic [4:0] PH_ALE_HOLD   = 5'h01;
	localparam logic [4:0] PH_PROGRAM_STORE_STROBE_N       = 5'h03;
	localparam logic [4:0] PH_FLOAT      = 5'h01;
	localparam logic [4:0] PH_RW_GAP     = 5'h03;
	localparam logic [4:0] PH_RW         = 5'h06;
	localparam logic [4:0] PH_WR_HOLD    = 5'h01;
	localparam logic [4:0] PH_RD_FLOAT   = 5'h02;
	localparam logic [4:0] PH_PORT_SAMPLE = 5'h01;
	localparam logic [4:0] PH_PORT_UPDATE = 5'h02;

	typedef enum logic [1:0] {
		EMB_OP_FETCH = 2'b00,
		EMB_OP_READ  = 2'b01,
		EMB_OP_WRITE = 2'b10,
		EMB_OP_PORT  = 2'b11
	} emb_op_t;

	typedef enum logic [3:0] {
		EMB_IDLE    = 4'b0000,
		EMB_SETUP   = 4'b0001,
		EMB_ALE     = 4'b0010,
		EMB_AHOLD   = 4'b0011,
		EMB_STROBE  = 4'b0100,
		EMB_POST    = 4'b0101,
		EMB_DONE    = 4'b0110
	} emb_state_t;
endpackage

//--- common/emb_tick_if.sv
interface emb_tick_if;
	logic tick;
	logic clear;
	modport gen (output tick, input clear);
	modport use_ (input tick, output clear);
endinterface

//--- logic/emb_tick_gen.sv
module emb_tick_gen (
	input  wire logic ref_clk,
	input  wire logic nrst,
	emb_tick_if.gen   tk
);
	logic [3:0] cnt;
	logic [3:0] next_cnt;

	// ------------------------------------------------------------
	// oscillator-period enable
	// ------------------------------------------------------------
	always_comb begin
		if (tk.clear || cnt == emb_pkg::TCP_LAST)
			next_cnt = 4'h0;
		else
			next_cnt = cnt + 4'h1;
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst)
			cnt <= 4'h0;
		else
			cnt <= next_cnt;
	end

	assign tk.tick = !tk.clear && (cnt == emb_pkg::TCP_LAST);
endmodule

//--- logic/emb_bus_seq.sv
// Operation
// - address on high port holds steady through the whole cycle.
// - address valid one oscillator period before latch strobe rises.
// - address held one oscillator period after latch strobe falls.
// - fetch allows three periods of access time.
// - fetched data captured before store strobe rises.
// - data read allows eight periods total access.
// - write data driven two periods before write strobe falls.
// - write data held one period after write strobe rises.
// - port inputs sampled at state5_phase2, outputs updated after state6_phase2.
module emb_bus_seq (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic [1:0]  req_op,
	input  wire logic [15:0] req_addr,
	input  wire logic [7:0]  req_wdata,
	input  wire logic [7:0]  port_out_data,
	output logic             rsp_valid,
	output logic [7:0]       rsp_data,
	output logic [7:0]       port_in_data,
	input  wire logic [7:0]  port_pin_in,
	output logic [7:0]       port_pin_out,
	output logic [7:0]       low_addr_data_port_o,
	output logic             low_addr_data_port_oe,
	input  wire logic [7:0]  low_addr_data_port_i,
	output logic [7:0]       high_addr_port,
	output logic             addr_latch_strobe,
	output logic             program_store_strobe_n,
	output logic             read_strobe_n,
	output logic             write_strobe_n
);
	emb_tick_if tk ();

	emb_tick_gen u_tick (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.tk      (tk.gen)
	);

	emb_pkg::emb_state_t state;
	emb_pkg::emb_state_t next_state;
	emb_pkg::emb_op_t    op;
	emb_pkg::emb_op_t    next_op;
	logic [4:0]  per;
	logic [4:0]  next_per;
	logic [15:0] addr;
	logic [15:0] next_addr;
	logic [7:0]  wdat;
	logic [7:0]  next_wdat;
	logic [7:0]  rdat;
	logic [7:0]  next_rdat;
	logic [7:0]  pin_q;
	logic [7:0]  next_pin_q;
	logic [7:0]  pout;
	logic [7:0]  next_pout;
	logic        ale;
	logic        next_ale;
	logic        strb;
	logic        next_strb;
	logic        drv_addr;
	logic        next_drv_addr;
	logic        drv_data;
	logic        next_drv_data;
	logic        done;
	logic        next_done;
	logic [7:0]  p_s1, p_s2, p_s3;
	logic [7:0]  d_s1, d_s2, d_s3;
	logic [7:0]  pin_stable;
	logic [7:0]  next_pin_stable;
	logic [7:0]  bus_stable;
	logic [7:0]  next_bus_stable;

	// ------------------------------------------------------------
	// pin synchronisers: accept a change once stages two and three agree
	// ------------------------------------------------------------
	function automatic logic [7:0] agree(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] old);
		agree = (a == b) ? a : old;
	endfunction

	always_comb begin
		next_pin_stable = agree(p_s2, p_s3, pin_stable);
		next_bus_stable = agree(d_s2, d_s3, bus_stable);
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			p_s1       <= 8'h00;
			p_s2       <= 8'h00;
			p_s3       <= 8'h00;
			d_s1       <= 8'h00;
			d_s2       <= 8'h00;
			d_s3       <= 8'h00;
			pin_stable <= 8'h00;
			bus_stable <= 8'h00;
		end else begin
			p_s1       <= port_pin_in;
			p_s2       <= p_s1;
			p_s3       <= p_s2;
			d_s1       <= low_addr_data_port_i;
			d_s2       <= d_s1;
			d_s3       <= d_s2;
			pin_stable <= next_pin_stable;
			bus_stable <= next_bus_stable;
		end
	end

	// ------------------------------------------------------------
	// bus cycle sequencer, advanced once per oscillator period outside EMB_IDLE and EMB_DONE
	// ------------------------------------------------------------
	assign tk.clear = (state == emb_pkg::EMB_IDLE);
	assign req_ready = (state == emb_pkg::EMB_IDLE);

	always_comb begin
		next_state    = state;
		next_op       = op;
		next_per      = per;
		next_addr     = addr;
		next_wdat     = wdat;
		next_rdat     = rdat;
		next_pin_q    = pin_q;
		next_pout     = pout;
		next_ale      = ale;
		next_strb     = strb;
		next_drv_addr = drv_addr;
		next_drv_data = drv_data;
		next_done     = 1'b0;
		case (state)
			emb_pkg::EMB_IDLE: begin
				if (req_valid) begin
					next_op       = emb_pkg::emb_op_t'(req_op);
					next_addr     = req_addr;   // latched once, steady all cycle
					next_wdat     = req_wdata;
					next_drv_addr = 1'b1;
					next_per      = emb_pkg::PH_ADDR_SETUP;
					next_state    = emb_pkg::EMB_SETUP;
				end
			end
			emb_pkg::EMB_SETUP: begin
				if (tk.tick) begin
					// address has stood one full period before the latch strobe
					next_ale   = 1'b1;
					next_per   = emb_pkg::PH_ALE;
					next_state = emb_pkg::EMB_ALE;
				end
			end
			emb_pkg::EMB_ALE: begin
				if (tk.tick) begin
					if (per == emb_pkg::PH_PORT_SAMPLE && op == emb_pkg::EMB_OP_PORT)
						next_pin_q = pin_stable;   // state5_phase2 sample
					if (per == 5'h01) begin
						next_ale   = 1'b0;   // two-period latch pulse
						next_per   = emb_pkg::PH_ALE_HOLD;
						next_state = emb_pkg::EMB_AHOLD;
					end else
						next_per = per - 5'h01;
				end
			end
			emb_pkg::EMB_AHOLD: begin
				if (tk.tick) begin
					// address kept a period past latch fall
					if (op == emb_pkg::EMB_OP_READ || op == emb_pkg::EMB_OP_WRITE) begin
						if (per == emb_pkg::PH_ALE_HOLD) begin
							next_drv_addr = 1'b0;
							next_drv_data = (op == emb_pkg::EMB_OP_WRITE);
						end
						if (per == emb_pkg::PH_RW_GAP) begin
							next_strb  = 1'b1;   // three periods after latch fall
							next_per   = emb_pkg::PH_RW;
							next_state = emb_pkg::EMB_STROBE;
						end else
							next_per = per + 5'h01;
					end else if (op == emb_pkg::EMB_OP_FETCH) begin
						next_drv_addr = 1'b0;
						next_strb     = 1'b1;    // one period after latch fall
						next_per      = emb_pkg::PH_PROGRAM_STORE_STROBE_N;
						next_state    = emb_pkg::EMB_STROBE;
					end else begin
						next_drv_addr = 1'b0;
						next_per      = emb_pkg::PH_PORT_UPDATE;
						next_state    = emb_pkg::EMB_POST;
					end
				end
			end
			emb_pkg::EMB_STROBE: begin
				if (tk.tick) begin
					if (per == 5'h01) begin
						// capture before the strobe rises
						if (op != emb_pkg::EMB_OP_WRITE)
							next_rdat = bus_stable;
						next_strb  = 1'b0;
						next_per   = (op == emb_pkg::EMB_OP_FETCH) ? emb_pkg::PH_FLOAT :
							(op == emb_pkg::EMB_OP_WRITE) ? emb_pkg::PH_WR_HOLD :
							emb_pkg::PH_RD_FLOAT;   // float allowance
						next_state = emb_pkg::EMB_POST;
					end else
						next_per = per - 5'h01;   // six-period pulse for read and write, three for fetch
				end
			end
			emb_pkg::EMB_POST: begin
				if (tk.tick) begin
					if (per == 5'h01) begin
						next_drv_data = 1'b0;   // write data held one period
						if (op == emb_pkg::EMB_OP_PORT)
							next_pout = wdat;   // state6_phase2 update
						next_state = emb_pkg::EMB_DONE;
					end else
						next_per = per - 5'h01;
				end
			end
			emb_pkg::EMB_DONE: begin
				next_done  = 1'b1;
				next_state = emb_pkg::EMB_IDLE;
			end
			default: next_state = emb_pkg::EMB_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state    <= emb_pkg::EMB_IDLE;
			op       <= emb_pkg::EMB_OP_FETCH;
			per      <= 5'h00;
			addr     <= 16'h0000;
			wdat     <= 8'h00;
			rdat     <= 8'h00;
			pin_q    <= 8'h00;
			pout     <= 8'h00;
			ale      <= 1'b0;
			strb     <= 1'b0;
			drv_addr <= 1'b0;
			drv_data <= 1'b0;
			done     <= 1'b0;
		end else begin
			state    <= next_state;
			op       <= next_op;
			per      <= next_per;
			addr     <= next_addr;
			wdat     <= next_wdat;
			rdat     <= next_rdat;
			pin_q    <= next_pin_q;
			pout     <= next_pout;
			ale      <= next_ale;
			strb     <= next_strb;
			drv_addr <= next_drv_addr;
			drv_data <= next_drv_data;
			done     <= next_done;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign high_addr_port         = addr[15:8];
	assign low_addr_data_port_o   = drv_data ? wdat : addr[7:0];
	assign low_addr_data_port_oe  = drv_addr || drv_data;
	assign addr_latch_strobe      = ale;
	assign program_store_strobe_n = !(strb && op == emb_pkg::EMB_OP_FETCH);
	assign read_strobe_n          = !(strb && op == emb_pkg::EMB_OP_READ);
	assign write_strobe_n         = !(strb && op == emb_pkg::EMB_OP_WRITE);
	assign rsp_valid              = done;
	assign rsp_data               = (op == emb_pkg::EMB_OP_PORT) ? pin_q : rdat;
	assign port_in_data           = pin_q;
	assign port_pin_out           = pout;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_ale_fall;
		$fell(addr_latch_strobe);
	endsequence

	// the take edge itself loads addr, so only edges after it are checked
	a_addr_stable: assert property (@(posedge ref_clk) disable iff (!nrst)
		($past(state) != emb_pkg::EMB_IDLE && state != emb_pkg::EMB_IDLE)
		|-> $stable(addr))
		else $error("address changed mid cycle");
	a_ale_setup: assert property (@(posedge ref_clk) disable iff (!nrst)
		$rose(addr_latch_strobe) |-> $past(low_addr_data_port_oe, 6))
		else $error("address not set up before latch");
	a_ale_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
		s_ale_fall |-> low_addr_data_port_oe [*6])
		else $error("address hold too short");
	a_ale_width: assert property (@(posedge ref_clk) disable iff (!nrst)
		$rose(addr_latch_strobe) |->
		addr_latch_strobe [*8] ##1 addr_latch_strobe [*4] ##1 !addr_latch_strobe)
		else $error("latch strobe width wrong");
	a_program_store_strobe_n_width: assert property (@(posedge ref_clk) disable iff (!nrst)
		$fell(program_store_strobe_n) |-> !program_store_strobe_n [*8] ##1
		!program_store_strobe_n [*8] ##1 !program_store_strobe_n [*2] ##1
		program_store_strobe_n)
		else $error("store strobe too short");
	a_program_store_strobe_n_start: assert property (@(posedge ref_clk) disable iff (!nrst)
		s_ale_fall ##1 (op == emb_pkg::EMB_OP_FETCH) |-> ##[4:7] !program_store_strobe_n)
		else $error("store strobe late");
	a_wr_setup: assert property (@(posedge ref_clk) disable iff (!nrst)
		$fell(write_strobe_n) |-> $past(drv_data, 6))
		else $error("write data not set up");
	a_wr_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
		$rose(write_strobe_n) |-> drv_data [*6])
		else $error("write data hold too short");
	a_rw_start: assert property (@(posedge ref_clk) disable iff (!nrst)
		s_ale_fall ##1 (op == emb_pkg::EMB_OP_READ) |-> ##[16:19] !read_strobe_n)
		else $error("read strobe not three periods after latch");
endmodule

//--- dv/emb_mem_model.sv
module emb_mem_model (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       slow,
	input  wire logic [7:0] bus_o,
	input  wire logic       oe,
	input  wire logic [7:0] hi,
	input  wire logic       ale,
	input  wire logic       program_store_strobe_n_n,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	output logic [7:0]      bus_q,
	output int              errs
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------
	// limits in cycles
	// ----------------
	localparam int C   = emb_pkg::TCP_CYC;
	localparam int DM  = (emb_pkg::TCP_NS - emb_pkg::DELTA_NS + 7) / 8;
	localparam int ALW = (2 * emb_pkg::TCP_NS - emb_pkg::DELTA_NS + 7) / 8;
	localparam int PSW = (3 * emb_pkg::TCP_NS - emb_pkg::DELTA_NS + 7) / 8;
	localparam int RWW = (6 * emb_pkg::TCP_NS - emb_pkg::DELTA_NS + 7) / 8;
	localparam int RWH = (3 * emb_pkg::TCP_NS + emb_pkg::DELTA_NS) / 8;
	logic [7:0] mem [bit [15:0]];
	logic [7:0] lo, bus_p, hi_p, dat;
	logic       ale_q = 1'b0;
	logic       ps_q = 1'b1;
	logic       rw_q = 1'b1;
	logic       wr_q = 1'b1;
	logic       drv = 1'b0;
	logic       go;
	int         ale_n, low_n, stab, lim;
	int         since = 99;
	int         post = 99;
	wire        rw_n = rd_n & wr_n;
	wire [15:0] a = {hi, lo};
	initial errs = 0;
	initial bus_q = 8'h00;
	// ----------------
	// checks and data
	// ----------------
	always @(posedge ref_clk) begin
		lim = slow ? (program_store_strobe_n_n ? 4 * C : 2 * C) - 2 : 0;
		dat = mem.exists(a) ? mem[a] : a[7:0] ^ a[15:8] ^ 8'h5a;
		go = (!program_store_strobe_n_n || !rd_n) && low_n >= lim;
		if (nrst) begin
			if (oe && drv)
				errs++;
			if (ale_q && !ale && (stab < DM || ale_n < ALW))
				errs++;
			if (since < DM && (!oe || bus_o != bus_p))
				errs++;
			if (post < DM && (!oe || bus_o != bus_p))
				errs++;
			if (hi != hi_p && (ale || !program_store_strobe_n_n || !rw_n || since < DM))
				errs++;
			if ((ps_q && !program_store_strobe_n_n && since < DM) || (!ps_q && program_store_strobe_n_n && low_n < PSW))
				errs++;
			if (rw_q && !rw_n && (since < PSW || since > RWH || (!wr_n && stab < DM)))
				errs++;
			if (!rw_q && rw_n && low_n < RWW)
				errs++;
			if (!wr_q && wr_n)
				mem[a] = bus_o;
		end
		if (ale_q && !ale)
			lo <= bus_o;
		drv <= go;
		bus_q <= go ? dat : ~bus_q; // released bus keeps toggling
		ale_q <= ale;
		ps_q <= program_store_strobe_n_n;
		rw_q <= rw_n;
		wr_q <= wr_n;
		bus_p <= bus_o;
		hi_p <= hi;
		ale_n <= ale ? ale_n + 1 : 0;
		low_n <= (!program_store_strobe_n_n || !rw_n) ? low_n + 1 : 0;
		stab <= (oe && bus_o == bus_p) ? stab + 1 : int'(oe);
		since <= (!nrst) ? 99 : (ale_q && !ale) ? 0 : since + 1;
		post <= (!nrst) ? 99 : (!wr_q && wr_n) ? 0 : post + 1;
	end
endmodule

//--- dv/test_external_memory_bus_cycles.sv
module test_external_memory_bus_cycles;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [1:0]  op;
		logic [15:0] addr;
		logic [7:0]  wd;
		logic [7:0]  pins;
		logic [7:0]  exp;
	} emb_row_t;
	// ----------------
	// ordinary cases
	// ----------------
	emb_row_t    rows [6] = '{
		'{2'h0, 16'h1234, 8'h00, 8'h00, 8'h7c},
		'{2'h1, 16'hffff, 8'h00, 8'h00, 8'h5a},
		'{2'h2, 16'h00a5, 8'h3c, 8'h00, 8'h00},
		'{2'h1, 16'h00a5, 8'h00, 8'h00, 8'h3c},
		'{2'h3, 16'h8001, 8'hc3, 8'h96, 8'h96},
		'{2'h0, 16'h0000, 8'h00, 8'h00, 8'h5a}};
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        slow = 1'b0;
	logic        req_valid = 1'b0;
	logic [1:0]  req_op = 2'h0;
	logic [15:0] req_addr = 16'h0000;
	logic [7:0]  req_wdata = 8'h00;
	logic [7:0]  port_pin_in = 8'h00;
	logic        req_ready, rsp_valid, oe, ale, program_store_strobe_n_n, rd_n, wr_n;
	logic [7:0]  rsp_data, port_in_data, port_pin_out, bus_o, bus_i, mem_q, hi;
	int          errs;
	int          bad_count = 0;
	int          total_checks = 0;
	assign bus_i = oe ? bus_o : mem_q;
	always #(emb_pkg::CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
	emb_bus_seq DUT (.ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid),
		.req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
		.port_out_data(8'h00), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.port_in_data(port_in_data), .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
		.low_addr_data_port_o(bus_o), .low_addr_data_port_oe(oe),
		.low_addr_data_port_i(bus_i), .high_addr_port(hi), .addr_latch_strobe(ale),
		.program_store_strobe_n(program_store_strobe_n_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n));
	emb_mem_model mm (.ref_clk(ref_clk), .nrst(nrst), .slow(slow), .bus_o(bus_o), .oe(oe),
		.hi(hi), .ale(ale), .program_store_strobe_n_n(program_store_strobe_n_n), .rd_n(rd_n), .wr_n(wr_n), .bus_q(mem_q),
		.errs(errs));
	// ----------------
	// tasks
	// ----------------
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic issue(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d);
		int n;
		n = 0;
		req_op = op;
		req_addr = a;
		req_wdata = d;
		req_valid = 1'b1;
		while (req_ready !== 1'b1 && n < 50) begin
			@(posedge ref_clk);
			#1 n++;
		end
		@(posedge ref_clk);
		#1 req_valid = 1'b0;
	endtask
	task automatic run(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d);
		int n;
		n = 0;
		issue(op, a, d);
		while (rsp_valid !== 1'b1 && n < 300) begin
			@(posedge ref_clk);
			#1 n++;
		end
		chk("rsp_valid", 8'h01, {7'h00, rsp_valid});
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ----------------
	// sequence
	// ----------------
	initial begin
		repeat (16) @(posedge ref_clk);
		#1 chk("idle", 8'h74, {ale, program_store_strobe_n_n, rd_n, wr_n, oe, req_ready, rsp_valid, 1'b0});
		nrst = 1'b1;
		for (int p = 0; p < 2; p++) begin
			slow = 1'(p);
			foreach (rows[i]) begin
				port_pin_in = rows[i].pins;
				run(rows[i].op, rows[i].addr, rows[i].wd);
				if (rows[i].op != 2'h2)
					chk("rsp_data", rows[i].exp, rsp_data);
				if (rows[i].op == 2'h3)
					chk("port_pin_out", rows[i].wd, port_pin_out);
				if (rows[i].op == 2'h3)
					chk("port_in_data", rows[i].pins, port_in_data);
			end
		end
		port_pin_in = 8'ha5;
		fork
			run(2'h3, 16'h4321, 8'h18);
			begin
				@(negedge ale);
				#1 port_pin_in = 8'h5a;
			end
		join
		chk("port sample", 8'ha5, rsp_data);
		chk("port_pin_out", 8'h18, port_pin_out);
		issue(2'h1, 16'h2040, 8'h00);
		repeat (45) @(posedge ref_clk);
		#1 nrst = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 chk("idle", 8'h74, {ale, program_store_strobe_n_n, rd_n, wr_n, oe, req_ready, rsp_valid, 1'b0});
		nrst = 1'b1;
		run(2'h1, 16'h00a5, 8'h00);
		chk("rsp_data", 8'h3c, rsp_data);
		chk("model errors", 8'h00, 8'(errs));
		wrap_up();
	end
	initial begin
		#100_000;
		bad_count++;
		wrap_up();
	end
endmodule
